// ---- core/cdd_defs.vh ----
// Offsets, field positions and reset values of the speaker and dither bank
// What this block does
// [R1] Left speaker gain D7-D6: 0/6/12/18 dB
// [R2] Right speaker gain D5-D4: same four steps
// [R3] D3 write-only left speaker enable, reset 0
// [R4] D2 write-only right speaker enable, reset 0
// [R5] Host writes zeros to D1-D0
// [R6] Left dither level D7-D4, 0000 disables
// [R7] Right dither level D3-D0, same encoding
// [R8] Codes 0001-0111 give +15..+105 mV
// [R9] 1000 disables, 1001-1111 give -15..-105 mV
// [R10] Reserved addresses read-only, read as zero
// [R11] Host never writes reserved addresses
// [R12] Enable and reserved bits read back zero
`ifndef CDD_DEFS_VH
`define CDD_DEFS_VH

// ==========================================================================
// Register offsets
`define CDD_OFS_RSVD_A        8'h45
`define CDD_OFS_RSVD_B        8'h46
`define CDD_OFS_RSVD_C        8'h47
`define CDD_OFS_RSVD_D        8'h48
`define CDD_OFS_SPK_CTRL      8'h49
`define CDD_OFS_RSVD_E        8'h4a
`define CDD_OFS_RSVD_F        8'h4b
`define CDD_OFS_DITHER_CTRL   8'h4c
`define CDD_OFS_RSVD_G        8'h4d
`define CDD_OFS_RSVD_H        8'h4e
`define CDD_OFS_RSVD_I        8'h4f
`define CDD_OFS_FIRST         8'h45
`define CDD_OFS_LAST          8'h4f

// ==========================================================================
// Field positions
`define CDD_SPK_GAIN_L_HI     7
`define CDD_SPK_GAIN_L_LO     6
`define CDD_SPK_GAIN_R_HI     5
`define CDD_SPK_GAIN_R_LO     4
`define CDD_SPK_EN_L_BIT      3
`define CDD_SPK_EN_R_BIT      2
`define CDD_SPK_RSVD_HI       1
`define CDD_SPK_RSVD_LO       0
`define CDD_DIT_L_HI          7
`define CDD_DIT_L_LO          4
`define CDD_DIT_R_HI          3
`define CDD_DIT_R_LO          0

// ==========================================================================
// Reset values and encodings
`define CDD_RST_GAIN          2'h0
`define CDD_RST_EN            1'h0
`define CDD_RST_DITHER        4'h0
`define CDD_RSVD_VALUE        8'h00
`define CDD_GAIN_STEP_DB      5'h06
`define CDD_DITHER_STEP_MV    7'h0f

`endif

// ---- core/cdd_spk_chan.v ----
// One speaker amplifier channel: stored gain and enable, decoded gain in dB
`timescale 1ns/1ps
`default_nettype none
`include "cdd_defs.vh"

module cdd_spk_chan
(
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  // Write strobe and fields
  input  wire       wr_stb,
  input  wire [1:0] gain_in,
  input  wire       en_in,
  // Channel controls
  output reg  [1:0] gain_reg,
  output reg        en_reg,
  output reg  [4:0] gain_db_reg
);

  // ========================================================================
  // Gain code to dB, 6 dB per step
  function [4:0] gain_to_db;
    input [1:0] code;
    begin
      gain_to_db = {3'h0, code} * `CDD_GAIN_STEP_DB;
    end
  endfunction

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gain_reg    <= `CDD_RST_GAIN;
      en_reg      <= `CDD_RST_EN;
      gain_db_reg <= 5'h00;
    end
    else if (wr_stb)
    begin
      gain_reg    <= gain_in;                 // [R1]
      en_reg      <= en_in;                   // [R3]
      gain_db_reg <= gain_to_db(gain_in);     // [R2]
    end
  end

endmodule // cdd_spk_chan
`default_nettype wire

// ---- core/cdd_dither_dec.v ----
// Decodes one four-bit dither code into enable, sign and magnitude in mV
`timescale 1ns/1ps
`default_nettype none
`include "cdd_defs.vh"

module cdd_dither_dec
(
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  // Stored code
  input  wire [3:0] code,
  // Decoded level
  output reg        on_reg,
  output reg        neg_reg,
  output reg  [6:0] mv_reg
);

  // ========================================================================
  // Magnitude, 15 mV per step of the low three bits
  function [6:0] step_to_mv;
    input [2:0] step;
    begin
      step_to_mv = {4'h0, step} * `CDD_DITHER_STEP_MV;
    end
  endfunction

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on_reg  <= 1'b0;
      neg_reg <= 1'b0;
      mv_reg  <= 7'h00;
    end
    else
    begin
      on_reg  <= (code[2:0] != 3'h0);         // [R6]
      neg_reg <= code[3] && (code[2:0] != 3'h0); // [R9]
      mv_reg  <= step_to_mv(code[2:0]);       // [R8]
    end
  end

endmodule // cdd_dither_dec
`default_nettype wire

// ---- core/cdd_regs.v ----
// Register bank for speaker amplifier control and ADC dither levels
`timescale 1ns/1ps
`default_nettype none
`include "cdd_defs.vh"

module cdd_regs
(
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  output reg        reg_rvalid,
  output reg        reg_hit,
  // Access faults
  output reg        rsvd_wr_pulse,
  output reg        rsvd_bits_pulse,
  // Left speaker channel
  output wire [1:0] spk_gain_l,
  output wire       spk_en_l,
  output wire [4:0] spk_gain_db_l,
  // Right speaker channel
  output wire [1:0] spk_gain_r,
  output wire       spk_en_r,
  output wire [4:0] spk_gain_db_r,
  // Left ADC dither
  output wire [3:0] dither_code_l,
  output wire       dither_on_l,
  output wire       dither_neg_l,
  output wire [6:0] dither_mv_l,
  // Right ADC dither
  output wire [3:0] dither_code_r,
  output wire       dither_on_r,
  output wire       dither_neg_r,
  output wire [6:0] dither_mv_r
);

  // ========================================================================
  // Address decode
  function in_bank;
    input [7:0] a;
    begin
      in_bank = (a >= `CDD_OFS_FIRST) && (a <= `CDD_OFS_LAST);
    end
  endfunction

  wire       wr_spk;
  wire       wr_dit;
  wire       wr_rsvd;
  reg  [7:0] dither_reg;
  reg  [7:0] rd_next;

  assign wr_spk  = reg_wr && (reg_addr == `CDD_OFS_SPK_CTRL);
  assign wr_dit  = reg_wr && (reg_addr == `CDD_OFS_DITHER_CTRL);
  // Reserved locations swallow writes
  assign wr_rsvd = reg_wr && in_bank(reg_addr) && !wr_spk && !wr_dit; // [R10]

  // ========================================================================
  // Speaker amplifier channels
  cdd_spk_chan u_spk_l
  (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .wr_stb      (wr_spk),
    .gain_in     (reg_wdata[`CDD_SPK_GAIN_L_HI:`CDD_SPK_GAIN_L_LO]), // [R1]
    .en_in       (reg_wdata[`CDD_SPK_EN_L_BIT]),                     // [R3]
    .gain_reg    (spk_gain_l),
    .en_reg      (spk_en_l),
    .gain_db_reg (spk_gain_db_l)
  );

  cdd_spk_chan u_spk_r
  (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .wr_stb      (wr_spk),
    .gain_in     (reg_wdata[`CDD_SPK_GAIN_R_HI:`CDD_SPK_GAIN_R_LO]), // [R2]
    .en_in       (reg_wdata[`CDD_SPK_EN_R_BIT]),                     // [R4]
    .gain_reg    (spk_gain_r),
    .en_reg      (spk_en_r),
    .gain_db_reg (spk_gain_db_r)
  );

  // ========================================================================
  // Dither level register
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      dither_reg <= {`CDD_RST_DITHER, `CDD_RST_DITHER};
    else if (wr_dit)
      dither_reg <= reg_wdata;                // [R6] [R7]
  end

  assign dither_code_l = dither_reg[`CDD_DIT_L_HI:`CDD_DIT_L_LO];
  assign dither_code_r = dither_reg[`CDD_DIT_R_HI:`CDD_DIT_R_LO];

  cdd_dither_dec u_dit_l
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .code    (dither_code_l),
    .on_reg  (dither_on_l),
    .neg_reg (dither_neg_l),
    .mv_reg  (dither_mv_l)
  );

  cdd_dither_dec u_dit_r
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .code    (dither_code_r),                 // [R7]
    .on_reg  (dither_on_r),
    .neg_reg (dither_neg_r),
    .mv_reg  (dither_mv_r)
  );

  // ========================================================================
  // Read mux
  always @*
  begin
    rd_next = `CDD_RSVD_VALUE;
    case (reg_addr)
      `CDD_OFS_SPK_CTRL:
        rd_next = {spk_gain_l, spk_gain_r, 4'h0}; // [R12]
      `CDD_OFS_DITHER_CTRL:
        rd_next = dither_reg;
      default:
        rd_next = `CDD_RSVD_VALUE;            // [R10]
    endcase
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
      reg_hit    <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        reg_rdata <= rd_next;
        reg_hit   <= in_bank(reg_addr);
      end
    end
  end

  // ========================================================================
  // Host misuse indications
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsvd_wr_pulse   <= 1'b0;
      rsvd_bits_pulse <= 1'b0;
    end
    else
    begin
      rsvd_wr_pulse   <= wr_rsvd;             // [R11]
      rsvd_bits_pulse <= wr_spk &&
        (reg_wdata[`CDD_SPK_RSVD_HI:`CDD_SPK_RSVD_LO] != 2'h0); // [R5]
    end
  end

endmodule // cdd_regs
`default_nettype wire

// ---- verif/cdd_regs_sva.sv ----
// Checker for the speaker and dither register bank
`timescale 1ns/1ps
`default_nettype none
module cdd_regs_sva
(
  // Clock, reset and register port
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       rsvd_wr_pulse,
  // Channel outputs
  input wire logic [1:0] spk_gain_l,
  input wire logic [1:0] spk_gain_r,
  input wire logic       spk_en_l,
  input wire logic       spk_en_r,
  input wire logic [4:0] spk_gain_db_l,
  input wire logic [3:0] dither_code_l,
  input wire logic [3:0] dither_code_r,
  input wire logic       dither_on_l,
  input wire logic       dither_neg_l,
  input wire logic [6:0] dither_mv_l
);
  logic rsvd;
  assign rsvd = reg_addr >= 8'h45 && reg_addr <= 8'h4f
    && reg_addr != 8'h49 && reg_addr != 8'h4c;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence spk_wr; reg_wr && reg_addr == 8'h49; endsequence
  sequence dit_wr; reg_wr && reg_addr == 8'h4c; endsequence
  // ==========================================================
  // Assertions
  AST_GAIN: assert property (spk_wr |=>
    {spk_gain_l, spk_gain_r} == $past(reg_wdata[7:4]))
    else $error("speaker gain not stored");
  AST_EN: assert property (spk_wr |=>
    {spk_en_l, spk_en_r} == $past(reg_wdata[3:2]))
    else $error("speaker enable not stored");
  AST_DB: assert property (spk_gain_db_l == spk_gain_l * 5'h06)
    else $error("gain in dB wrong");
  AST_DIT: assert property (dit_wr |=>
    {dither_code_l, dither_code_r} == $past(reg_wdata))
    else $error("dither code not stored");
  AST_MV: assert property (1 |=>
    dither_mv_l == $past(dither_code_l[2:0]) * 7'h0f)
    else $error("dither magnitude wrong");
  AST_SIGN: assert property (1 |=>
    dither_on_l == $past(|dither_code_l[2:0]) && dither_neg_l ==
    $past(dither_code_l[3] && |dither_code_l[2:0]))
    else $error("dither sign or enable wrong");
  AST_RD_SPK: assert property (reg_rd && reg_addr == 8'h49 |=>
    reg_rvalid && reg_rdata == {$past(spk_gain_l), $past(spk_gain_r), 4'h0})
    else $error("speaker control readback wrong");
  AST_RD_RSVD: assert property (reg_rd && rsvd |=>
    reg_rvalid && reg_rdata == 8'h00)
    else $error("reserved read not zero");
  AST_WR_RSVD: assert property (reg_wr && rsvd |=>
    rsvd_wr_pulse && $stable(dither_code_l))
    else $error("reserved write not refused");
endmodule // cdd_regs_sva
bind cdd_regs cdd_regs_sva u_sva (.sys_clk, .rst_n, .reg_addr, .reg_wr,
  .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .rsvd_wr_pulse, .spk_gain_l,
  .spk_gain_r, .spk_en_l, .spk_en_r, .spk_gain_db_l, .dither_code_l,
  .dither_code_r, .dither_on_l, .dither_neg_l, .dither_mv_l);
`default_nettype wire

// ---- verif/cdd_regs_bench.sv ----
// Self-checking bench for the speaker and dither register bank
`timescale 1ns/1ps
`default_nettype none
module cdd_regs_bench;
  logic       sys_clk, rst_n, reg_wr, reg_rd, reg_rvalid, reg_hit;
  logic       rsvd_wr_pulse, rsvd_bits_pulse, spk_en_l, spk_en_r;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] spk_gain_l, spk_gain_r;
  logic [4:0] spk_gain_db_l, spk_gain_db_r;
  logic [3:0] dither_code_l, dither_code_r;
  logic       dither_on_l, dither_neg_l, dither_on_r, dither_neg_r;
  logic [6:0] dither_mv_l, dither_mv_r;
  int         fail_count = 0;
  int         n_compared = 0;
  int         i;
  cdd_regs DUT (.sys_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .reg_rvalid, .reg_hit, .rsvd_wr_pulse, .rsvd_bits_pulse,
    .spk_gain_l, .spk_en_l, .spk_gain_db_l, .spk_gain_r, .spk_en_r,
    .spk_gain_db_r, .dither_code_l, .dither_on_l, .dither_neg_l,
    .dither_mv_l, .dither_code_r, .dither_on_r, .dither_neg_r, .dither_mv_r);
  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk({reg_rvalid, reg_rdata}, {1'b1, e});
    chk(reg_hit, a >= 8'h45 && a <= 8'h4f);
  endtask
  function automatic logic [8:0] exp_dit(input logic [3:0] c);
    exp_dit = {|c[2:0], c[3] & |c[2:0], 7'(c[2:0] * 15)};
  endfunction
  task automatic print_verdict();
    $display("Compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog and tests
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial
  begin
    #20000;
    fail_count++;
    print_verdict();
  end
  initial
  begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    for (i = 8'h45; i <= 8'h50; i++)
      rd(i[7:0], 8'h00);
    for (i = 0; i < 4; i++)
    begin
      wr(8'h49, {i[1:0], ~i[1:0], i[0], i[1], 2'b00});
      chk({spk_gain_l, spk_gain_r, spk_en_l, spk_en_r},
        {i[1:0], ~i[1:0], i[0], i[1]});
      chk({spk_gain_db_l, spk_gain_db_r},
        {5'(i * 6), 5'(18 - i * 6)});
      rd(8'h49, {i[1:0], ~i[1:0], 4'h0});
    end
    for (i = 0; i < 16; i++)
    begin
      wr(8'h4c, {i[3:0], ~i[3:0]});
      chk({dither_code_l, dither_code_r}, {i[3:0], ~i[3:0]});
      @(negedge sys_clk);
      chk({dither_on_l, dither_neg_l, dither_mv_l}, exp_dit(i[3:0]));
      chk({dither_on_r, dither_neg_r, dither_mv_r}, exp_dit(~i[3:0]));
    end
    rd(8'h4c, 8'hf0);
    wr(8'h47, 8'hff);
    chk(rsvd_wr_pulse, 1'b1);
    rd(8'h47, 8'h00);
    wr(8'h49, 8'h03);
    chk(rsvd_bits_pulse, 1'b1);
    print_verdict();
  end
endmodule // cdd_regs_bench
`default_nettype wire
